// ### core/dmc_defines.svh
`ifndef DMC_DEFINES_SVH
`define DMC_DEFINES_SVH
`define DMC_NUM_CH        3
`define DMC_NUM_SRC       8
`define DMC_ADDR_W        16
`define DMC_BASE_LATENCY  2
`define DMC_WRITE_PENALTY 3
`define DMC_CPU_GAP       1
`define DMC_MODE_INC      2'h1
`define DMC_MODE_DEC      2'h2
`define DMC_MODE_STATIC   2'h0
`endif

// ### core/dmc_pkg.sv
package dmc_pkg;
	typedef enum logic [1:0] {
		DMC_ADDR_STATIC,
		DMC_ADDR_INC,
		DMC_ADDR_DEC,
		DMC_ADDR_RSVD
	} dmc_addr_mode_t;
	typedef enum {
		DMC_IDLE,
		DMC_WAIT,
		DMC_MOVE,
		DMC_GAP
	} dmc_state_t;
endpackage

// ### core/dmc_alu_if.sv
interface dmc_alu_if;
	logic [15:0] base;
	logic [15:0] count;
	logic [1:0]  mode;
	logic        word;
	logic [15:0] addr;
	modport core (output base, output count, output mode, output word, input addr);
	modport alu  (input base, input count, input mode, input word, output addr);
endinterface

// ### core/dmc_alu.sv
`include "dmc_defines.svh"
module dmc_alu
	import dmc_pkg::*;
(
	dmc_alu_if.alu p
);
	// ================================
	// Address arithmetic, 16 bits wide
	always_comb begin
		unique case (p.mode)
			`DMC_MODE_INC: p.addr = p.base + p.count;
			`DMC_MODE_DEC: p.addr = p.base - p.count;
			default: begin
				// Word static alternates low/high byte
				p.addr = p.word ? (p.base + {15'h0, p.count[0]}) : p.base;
			end
		endcase
	end
endmodule

// ### core/dmc_channel_engine.sv
// Behaviour
// - Software transfer starts only if enabled, source assigned, trigger bit set.
// - Byte counter per channel increments for every byte moved.
// - Counter equal to block length sets the channel completion flag.
// - Completion flag with interrupt enable raises CPU interrupt request.
// - Single active channel is serviced after two cycles latency.
// - Writes to another channel's registers mid-transfer add three cycles.
// - Lower priority channels wait behind higher priority channels.
// - At least one CPU cycle between transfers of successive channels.
// - Addresses come from a 16-bit arithmetic unit, 16 bits wide.
// - Source and destination bases are fixed pointers, never modified.
// - Incrementing address is base plus byte counter.
// - Decrementing address is base minus byte counter.
// - Static address in byte mode is the unmodified base.
// - Finite mode clears transfer enable when block length is reached.
// - Loop mode keeps the channel enabled and restarts from bases.
// - Byte k uses base plus or minus k-1, or base.
// - Word mode moves two bytes; static alternates base and base plus one.
// - Eight transfer source inputs; each channel selects one.
`include "dmc_defines.svh"
module dmc_channel_engine
	import dmc_pkg::*;
#(
	parameter int NCH = `DMC_NUM_CH,
	parameter int NSRC = `DMC_NUM_SRC
)(
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire logic [NCH-1:0]       enable_set,
	input  wire logic [NCH-1:0]       enable_clr,
	input  wire logic [NSRC-1:0]      software_trigger_bit,
	input  wire logic [NCH*3-1:0]     transfer_source_select,
	input  wire logic [NCH*2-1:0]     src_mode,
	input  wire logic [NCH*2-1:0]     dst_mode,
	input  wire logic [NCH-1:0]       byte_word_select,
	input  wire logic [NCH-1:0]       channel_loop_select,
	input  wire logic [NCH-1:0]       channel_interrupt_enable,
	input  wire logic [NCH*16-1:0]    src_base,
	input  wire logic [NCH*16-1:0]    dst_base,
	input  wire logic [NCH*16-1:0]    channel_block_length,
	input  wire logic [NCH-1:0]       chan_reg_write,
	input  wire logic [NCH-1:0]       flag_clr,
	output logic [NCH-1:0]            channel_transfer_enable,
	output logic [NCH-1:0]            channel_completion_flag,
	output logic                      cpu_irq_ff,
	output logic                      bus_valid_ff,
	output logic [15:0]               bus_src_addr_ff,
	output logic [15:0]               bus_dst_addr_ff,
	output logic [1:0]                bus_chan_ff,
	output logic [NCH*16-1:0]         byte_count
);
	// ================================
	// State
	logic [NCH-1:0]      ten_ff, nxt_ten, flag_ff, nxt_flag;
	logic [15:0]         cnt_ff [NCH];
	logic [15:0]         nxt_cnt [NCH];
	dmc_state_t          st_ff, nxt_st;
	logic [2:0]          lat_ff, nxt_lat;
	logic [1:0]          ch_ff, nxt_ch, last_ff, nxt_last;
	logic                irq_nxt, valid_nxt;
	logic [15:0]         sa_nxt, da_nxt;
	logic [NCH-1:0]      req;
	dmc_alu_if           s_if ();
	dmc_alu_if           d_if ();

	dmc_alu u_src (.p(s_if));
	dmc_alu u_dst (.p(d_if));

	function automatic logic [1:0] pick(input logic [NCH-1:0] r);
		pick = 2'h0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (r[i]) begin
				pick = i[1:0];
			end
		end
	endfunction

	// ================================
	// Request qualification
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			// Source select picks one of eight inputs
			req[i] = ten_ff[i] && software_trigger_bit[transfer_source_select[i*3 +: 3]];
		end
	end

	// Bases go straight to the ALU; no register ever writes them back
	assign s_if.base  = src_base[ch_ff*16 +: 16];
	assign d_if.base  = dst_base[ch_ff*16 +: 16];
	assign s_if.count = cnt_ff[ch_ff];
	assign d_if.count = cnt_ff[ch_ff];
	assign s_if.mode  = src_mode[ch_ff*2 +: 2];
	assign d_if.mode  = dst_mode[ch_ff*2 +: 2];
	assign s_if.word  = byte_word_select[ch_ff];
	assign d_if.word  = byte_word_select[ch_ff];

	// ================================
	// Scheduler and counters
	always_comb begin
		nxt_st = st_ff;
		nxt_lat = lat_ff;
		nxt_ch = ch_ff;
		nxt_last = last_ff;
		nxt_ten = (ten_ff | enable_set) & ~enable_clr;
		nxt_flag = flag_ff & ~flag_clr;
		valid_nxt = 1'b0;
		sa_nxt = bus_src_addr_ff;
		da_nxt = bus_dst_addr_ff;
		for (int i = 0; i < NCH; i++) begin
			nxt_cnt[i] = cnt_ff[i];
		end
		unique case (st_ff)
			DMC_IDLE: begin
				if (|req) begin
					nxt_ch = pick(req);
					nxt_lat = 3'(`DMC_BASE_LATENCY - 1);
					nxt_st = DMC_WAIT;
				end
			end
			DMC_WAIT: begin
				// Foreign channel writes stall the service
				if ((chan_reg_write & ~(NCH'(1) << ch_ff)) != '0) begin
					// Penalty replaces this cycle's countdown, so add one less
					nxt_lat = lat_ff + 3'(`DMC_WRITE_PENALTY - 1);
				end else if (lat_ff != 3'h0) begin
					nxt_lat = lat_ff - 3'h1;
				end else begin
					nxt_st = DMC_MOVE;
				end
			end
			DMC_MOVE: begin
				valid_nxt = 1'b1;
				sa_nxt = s_if.addr;
				da_nxt = d_if.addr;
				nxt_cnt[ch_ff] = cnt_ff[ch_ff] + 16'h1;
				nxt_last = ch_ff;
				if (cnt_ff[ch_ff] + 16'h1 == channel_block_length[ch_ff*16 +: 16]) begin
					nxt_flag[ch_ff] = 1'b1;
					if (channel_loop_select[ch_ff]) begin
						nxt_cnt[ch_ff] = 16'h0;
					end else begin
						nxt_ten[ch_ff] = 1'b0;
					end
				end
				// Word mode: high byte moves in the next cycle
				if (byte_word_select[ch_ff] && !cnt_ff[ch_ff][0] && nxt_cnt[ch_ff] != 16'h0) begin
					nxt_st = DMC_MOVE;
				end else begin
					nxt_st = DMC_GAP;
				end
			end
			DMC_GAP: begin
				// One cycle left to the CPU before next channel
				nxt_st = DMC_IDLE;
			end
		endcase
		irq_nxt = |(nxt_flag & channel_interrupt_enable);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_ff <= DMC_IDLE;
			lat_ff <= 3'h0;
			ch_ff <= 2'h0;
			last_ff <= 2'h0;
			ten_ff <= '0;
			flag_ff <= '0;
			cpu_irq_ff <= 1'b0;
			bus_valid_ff <= 1'b0;
			bus_src_addr_ff <= 16'h0;
			bus_dst_addr_ff <= 16'h0;
			bus_chan_ff <= 2'h0;
			for (int i = 0; i < NCH; i++) begin
				cnt_ff[i] <= 16'h0;
			end
		end else begin
			st_ff <= nxt_st;
			lat_ff <= nxt_lat;
			ch_ff <= nxt_ch;
			last_ff <= nxt_last;
			ten_ff <= nxt_ten;
			flag_ff <= nxt_flag;
			cpu_irq_ff <= irq_nxt;
			bus_valid_ff <= valid_nxt;
			bus_src_addr_ff <= sa_nxt;
			bus_dst_addr_ff <= da_nxt;
			bus_chan_ff <= ch_ff;
			for (int i = 0; i < NCH; i++) begin
				cnt_ff[i] <= nxt_cnt[i];
			end
		end
	end

	assign channel_transfer_enable = ten_ff;
	assign channel_completion_flag = flag_ff;
	generate
		for (genvar g = 0; g < NCH; g++) begin : g_cnt
			assign byte_count[g*16 +: 16] = cnt_ff[g];
		end
	endgenerate
endmodule

// ### testbench/dmc_engine_sva.sv
//==========
// Checker
module dmc_engine_sva (
	input wire logic		clk,
	input wire logic		resetn,
	input wire logic [5:0]	src_mode,
	input wire logic [2:0]	channel_loop_select,
	input wire logic [47:0]	src_base,
	input wire logic [2:0]	channel_transfer_enable,
	input wire logic [2:0]	channel_completion_flag,
	input wire logic		cpu_irq_ff,
	input wire logic		bus_valid_ff,
	input wire logic [15:0]	bus_src_addr_ff,
	input wire logic [1:0]	bus_chan_ff,
	input wire logic [47:0]	byte_count
);
	timeunit 1ns;
	timeprecision 1ns;
	logic	v0;
	assign v0 = bus_valid_ff && bus_chan_ff == 2'h0;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Count, address, stop and wrap checks on channel 0 only, the other slices are alike
	sequence s_done0;
		$rose(channel_completion_flag[0]);
	endsequence
	AST_GAP:
	assert property (bus_valid_ff && $past(bus_valid_ff) |-> bus_chan_ff == $past(bus_chan_ff))
		else $error("channel switch without gap");
	AST_EN:
	assert property (bus_valid_ff |-> ($past(channel_transfer_enable) & (3'h1 << bus_chan_ff)) != 0)
		else $error("byte on disabled channel");
	AST_CNT:
	assert property (v0 && byte_count[15:0] != 16'h0
		|-> byte_count[15:0] == $past(byte_count[15:0]) + 16'h1) else $error("count step");
	AST_INC:
	assert property (v0 && src_mode[1:0] == 2'h1
		|-> bus_src_addr_ff == src_base[15:0] + $past(byte_count[15:0])) else $error("inc addr");
	AST_DEC:
	assert property (v0 && src_mode[1:0] == 2'h2
		|-> bus_src_addr_ff == src_base[15:0] - $past(byte_count[15:0])) else $error("dec addr");
	AST_STOP:
	assert property (s_done0 ##0 !channel_loop_select[0] |-> !channel_transfer_enable[0])
		else $error("finite channel kept enabled");
	AST_WRAP:
	assert property (s_done0 ##0 channel_loop_select[0]
		|-> channel_transfer_enable[0] && byte_count[15:0] == 16'h0) else $error("loop wrap");
	AST_IRQ:
	assert property (cpu_irq_ff |-> |(channel_completion_flag | $past(channel_completion_flag)))
		else $error("irq without flag");
endmodule
bind dmc_channel_engine dmc_engine_sva chk_u (.*);

// ### testbench/dmc_sw_partner.sv
//==========
// Software side, length from unit count
module dmc_sw_partner (
	input wire logic [2:0]	word_sel,
	input wire logic [5:0]	units,
	output logic [47:0]	len
);
	timeunit 1ns;
	timeprecision 1ns;
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			len[16*i+:16] = 16'(units[2*i+:2]) << word_sel[i];
		end
	end
endmodule

// ### testbench/dma_channel_address_and_trigger_test.sv
//==========
// Bench
module dma_channel_address_and_trigger_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic		clk = 0, resetn = 0, irq, vld;
	logic [1:0]	ch;
	logic [2:0]	en = 0, bw = 0, lp = 0, ie = 0, crw = 0, msk, ten, flg;
	logic [5:0]	sm = 0, dm = 0, un = 0;
	logic [7:0]	trg = 0;
	logic [8:0]	sel = 0;
	logic [15:0]	sa, da;
	logic [31:0]	seed = 93, r;
	logic [47:0]	sb = 0, db = 0, len, cnt;
	int		err_total = 0, checks = 0, cyc = 0, t0, ft, fc, k, w, n[3];
	always #5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	dmc_channel_engine dut_u (.clk(clk), .resetn(resetn), .enable_set(en), .enable_clr(3'h0),
		.software_trigger_bit(trg), .transfer_source_select(sel), .src_mode(sm), .dst_mode(dm),
		.byte_word_select(bw), .channel_loop_select(lp), .channel_interrupt_enable(ie),
		.src_base(sb), .dst_base(db), .channel_block_length(len), .chan_reg_write(crw),
		.flag_clr(3'h0), .channel_transfer_enable(ten), .channel_completion_flag(flg),
		.cpu_irq_ff(irq), .bus_valid_ff(vld), .bus_src_addr_ff(sa), .bus_dst_addr_ff(da),
		.bus_chan_ff(ch), .byte_count(cnt));
	dmc_sw_partner part_u (.word_sel(bw), .units(un), .len(len));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] xa(logic [15:0] b, logic [1:0] m, logic wd, int o);
		case (m)
			2'h1: return b + o[15:0];
			2'h2: return b - o[15:0];
			default: return b + (wd ? o[15:0] & 16'h1 : 16'h0);
		endcase
	endfunction
	function automatic bit done();
		for (int i = 0; i < 3; i++)
			if (msk[i] && n[i] < len[16*i+:16] + (lp[i] ? 2 : 0)) return 0;
		return 1;
	endfunction
	task automatic chk(logic [15:0] g, logic [15:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish();
		$display("mismatches %0d comparisons %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Model steps on the settled bus at the falling edge
	always @(negedge clk) begin
		if (resetn && vld === 1'b1) begin
			if (fc < 0) begin
				fc = ch;
				ft = cyc;
			end
			k = n[ch] % len[16*ch+:16];
			chk(16'(msk[ch] && (lp[ch] || n[ch] < len[16*ch+:16])), 1);
			n[ch]++;
			chk(sa, xa(sb[16*ch+:16], sm[2*ch+:2], bw[ch], k));
			chk(da, xa(db[16*ch+:16], dm[2*ch+:2], bw[ch], k));
			chk(cnt[16*ch+:16], 16'(k + 1 == len[16*ch+:16] && lp[ch] ? 0 : k + 1));
		end
	end
	initial begin
		for (int tr = 0; tr < 40; tr++) begin
			@(posedge clk);
			resetn <= 0;
			trg <= 0;
			r = rnd();
			msk = (r[2:0] == 0) ? 3'h1 : r[2:0];
			lp <= r[3] ? msk & ~(msk >> 1) & ~(msk >> 2) : 3'h0;
			ie <= r[6:4];
			w = $onehot(msk) && r[7];
			for (int i = 0; i < 3; i++) begin
				r = rnd();
				sm[2*i+:2] <= 2'(r[1:0] % 3);
				dm[2*i+:2] <= 2'(r[3:2] % 3);
				un[2*i+:2] <= 2'(r[5:4] % 3 + 1);
				sel[3*i+:3] <= r[8:6];
				bw[i] <= r[9];
				sb[16*i+:16] <= r[31:16];
				db[16*i+:16] <= r[25:10];
			end
			n = '{0, 0, 0};
			fc = -1;
			repeat (16) @(posedge clk);
			resetn <= 1;
			@(posedge clk);
			en <= msk;
			@(posedge clk);
			en <= 0;
			for (int i = 0; i < 3; i++) trg[sel[3*i+:3]] <= 1'b1;
			t0 = cyc + 1;
			@(posedge clk);
			crw <= (w != 0) ? {msk[1:0], msk[2]} : 3'h0;
			@(posedge clk);
			crw <= 0;
			for (int j = 0; j < 600 && !done(); j++) @(posedge clk);
			@(negedge clk);
			chk(16'(done()), 1);
			if ($onehot(msk)) chk(16'(ft - t0), 16'(4 + 3 * w));
			chk(16'(fc), 16'(msk[0] ? 0 : msk[1] ? 1 : 2));
			chk(ten, msk & lp);
			chk(flg, msk);
			chk(irq, |(msk & ie));
		end
		tally_and_finish();
	end
	initial begin
		#400000;
		err_total++;
		tally_and_finish();
	end
endmodule
